/* logic/dbg_pkg.sv */
// Constants, encodings and state types of the single-wire debug instruction layer
// What this block does
// R1: Indirect loads read at pointer, mode 0x1 post-increments, 32-bit
// R2: Load data leaves after guard bits on the first pass only
// R3: Host loads pointer, waits ack, then loads
// R4: Pointer mode 0x2 writes pointer, then ack
// R5: Mode 0x0 writes at pointer, 0x1 also advances
// R6: Every finished indirect write returns one ack
// R7: Control read returns one byte after guard
// R8: Control write takes one byte, no answer
// R9: Repeat counter runs next instruction count plus one
// R10: The repeat instruction itself never repeats
// R11: Later iterations need no sync or opcode
// R12: A break or a port disable stops a running repeat
// R13: Repeated writes take data frames, ack each
// R14: Repeated loads stream, guard before first only
// R15: Host resends address for repeated direct ops
// R16: Keys are 64-bit, info readout 128-bit max
// R17: No answer to keys, info after guard
// R18: Byte gap adds two idle bits between bytes
// R19: No guard bits between same-direction bytes
// R20: Info block readable always, 16 or 8 bytes
// R21: Info block field layout in ASCII bytes
// R22: Erase key starts erase, cleared by disable
// R23: Guard idle count set by control field
// R24: Direct write acks address and data
// R25: Repeat counter ends at zero after last pass
// R26: Pointer cleared by disable, wraps at width
package dbg_pkg;

  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_DREAD  = 3'h0;
  localparam logic [2:0] OP_ILOAD  = 3'h1;
  localparam logic [2:0] OP_DWRITE = 3'h2;
  localparam logic [2:0] OP_IWRITE = 3'h3;
  localparam logic [2:0] OP_CSRD   = 3'h4;
  localparam logic [2:0] OP_RPT    = 3'h5;
  localparam logic [2:0] OP_CSWR   = 3'h6;
  localparam logic [2:0] OP_KEY    = 3'h7;
  localparam int         OPC_POS   = 5;
  localparam int         MODE_POS  = 2;
  localparam int         INFO_POS  = 2;
  localparam logic [1:0] PTR_AT    = 2'h0;
  localparam logic [1:0] PTR_INC   = 2'h1;
  localparam logic [1:0] PTR_REG   = 2'h2;
  localparam logic [1:0] KLEN_8    = 2'h0;
  localparam logic [1:0] KLEN_16   = 2'h1;

  // ----------------------------------------------------------------
  // Link constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACK_BYTE       = 8'h40;
  localparam logic [3:0]  GAP_BITS       = 4'h2;
  localparam logic [4:0]  KEY_BYTES      = 5'h08;
  localparam logic [4:0]  INFO_SHORT     = 5'h08;
  localparam logic [4:0]  INFO_LONG      = 5'h10;
  localparam logic [63:0] CHIP_ERASE_KEY = 64'h4e564d4572617365;
  localparam logic [1:0]  PW_RESET       = 2'h3;

  // ----------------------------------------------------------------
  // Control/status space
  // ----------------------------------------------------------------
  localparam logic [3:0] CS_STATUS   = 4'h0;
  localparam logic [3:0] CS_CTRL     = 4'h2;
  localparam logic [7:0] CTRL_RESET  = 8'h01;
  localparam int         CTRL_GT_LSB = 0;
  localparam int         CTRL_GAP    = 7;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_LOCK   = 1;
  localparam int         STAT_KEY    = 2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_OPC  = 3'h1,
    S_ADDR = 3'h3,
    S_RXD  = 3'h2,
    S_BUS  = 3'h6,
    S_TX   = 3'h7
  } state_t;

  function automatic logic [2:0] op_class(input logic [7:0] op);
    return op[OPC_POS +: 3];
  endfunction : op_class

  function automatic logic [1:0] op_mode(input logic [7:0] op);
    return op[MODE_POS +: 2];
  endfunction : op_mode

  function automatic logic [4:0] op_bytes(input logic [7:0] op);
    return {3'h0, op[1:0]} + 5'h01;
  endfunction : op_bytes

endpackage : dbg_pkg

/* logic/cs_if.sv */
// Link between the instruction core and its control/status registers
`timescale 1ns/1ps
interface cs_if;
  logic       wr;
  logic       clr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] gt_len;
  logic       gap_en;
  logic       key_ok;
  logic       lock;
  logic       busy;

  modport regs (input wr, clr, addr, wdata, key_ok, lock, busy, output rdata, gt_len, gap_en);
  modport core (output wr, clr, addr, wdata, key_ok, lock, busy, input rdata, gt_len, gap_en);
endinterface : cs_if

/* logic/cs_regs.sv */
// Control/status register space shared by the link and the local register port
`timescale 1ns/1ps
module cs_regs (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  cs_if.regs              cs,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } regs_t;

  regs_t s_q;
  regs_t s_d;

  function automatic logic [7:0] cs_read(input logic [3:0] a, input logic [7:0] ctrl,
                                         input logic key_ok, input logic lock, input logic busy);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      dbg_pkg::CS_STATUS: begin
        v[dbg_pkg::STAT_BUSY] = busy;
        v[dbg_pkg::STAT_LOCK] = lock;
        v[dbg_pkg::STAT_KEY]  = key_ok;
      end
      dbg_pkg::CS_CTRL: v = ctrl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : cs_read

  always_comb begin
    s_d = s_q;
    // The link wins when both sides write in one cycle
    if (cs.wr && cs.addr == dbg_pkg::CS_CTRL) begin
      s_d.ctrl = cs.wdata; // see R23
    end else if (reg_wr && reg_addr == dbg_pkg::CS_CTRL) begin
      s_d.ctrl = reg_wdata;
    end
    s_d.rdata = reg_rd ? cs_read(reg_addr, s_q.ctrl, cs.key_ok, cs.lock, cs.busy) : 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || cs.clr) begin
      s_q <= '{ctrl: dbg_pkg::CTRL_RESET, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign cs.rdata   = cs_read(cs.addr, s_q.ctrl, cs.key_ok, cs.lock, cs.busy);
  assign cs.gt_len  = s_q.ctrl[dbg_pkg::CTRL_GT_LSB +: 3];
  assign cs.gap_en  = s_q.ctrl[dbg_pkg::CTRL_GAP];
  assign reg_rdata  = s_q.rdata;

  ctrl_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // see R23
    (cs.wr && cs.addr == dbg_pkg::CS_CTRL && !cs.clr) |=> cs.gt_len == $past(cs.wdata[2:0]))
    else $error("guard length not taken from control write");

endmodule : cs_regs

/* logic/onewire_debug_instruction_layer.sv */
// Instruction execution layer of the single-wire program and debug port
`timescale 1ns/1ps
module onewire_debug_instruction_layer #(
  parameter logic [127:0] INFO_BLOCK = {"3", " ", "P:0", "D:0", " ", "TESTDEV"},
  parameter logic [63:0]  ERASE_KEY  = dbg_pkg::CHIP_ERASE_KEY
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        port_disable,
  input  wire logic        rx_sync,
  input  wire logic        rx_break,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic      [3:0]  tx_idle,
  input  wire logic        tx_ready,
  output logic             bus_req,
  output logic             bus_we,
  output logic      [31:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  input  wire logic        bus_ack,
  input  wire logic [7:0]  bus_rdata,
  input  wire logic        lock_status,
  output logic             erase_start,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dbg_pkg::state_t st;
    logic [7:0]      op;
    logic [31:0]     ptr;
    logic [1:0]      pw;
    logic [31:0]     addr;
    logic [31:0]     data;
    logic [63:0]     key;
    logic [4:0]      idx;
    logic [4:0]      cnt;
    logic [7:0]      rpt;
    logic            turn;
    logic            ack;
    logic            mid;
    logic            key_ok;
    logic            erase;
    logic            tx_valid;
    logic [7:0]      tx_data;
    logic [3:0]      tx_idle;
    logic            bus_req;
    logic            bus_we;
    logic [31:0]     bus_addr;
    logic [7:0]      bus_wdata;
  } core_t;

  localparam core_t CORE_RESET = '{st: dbg_pkg::S_IDLE, pw: dbg_pkg::PW_RESET, default: '0};

  core_t s_q;
  core_t s_d;
  cs_if  cs ();

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    unique case (w)
      2'h0: return 32'h000000ff;
      2'h1: return 32'h0000ffff;
      2'h2: return 32'h00ffffff;
      2'h3: return 32'hffffffff;
    endcase
  endfunction : width_mask

  function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [4:0] i);
    return v[{i[1:0], 3'h0} +: 8];
  endfunction : byte_of

  function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [4:0] i, input logic [7:0] b);
    logic [31:0] r;
    r = v;
    r[{i[1:0], 3'h0} +: 8] = b;
    return r;
  endfunction : put_byte

  function automatic logic is_direct(input logic [7:0] op);
    return dbg_pkg::op_class(op) == dbg_pkg::OP_DREAD || dbg_pkg::op_class(op) == dbg_pkg::OP_DWRITE;
  endfunction : is_direct

  // ----------------------------------------------------------------
  // Control/status registers
  // ----------------------------------------------------------------
  cs_regs u_cs_regs (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .cs        (cs.regs),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // The opcode byte itself selects the register while it is being decoded
  assign cs.addr   = (s_q.st == dbg_pkg::S_OPC) ? rx_data[3:0] : s_q.op[3:0];
  assign cs.wr     = s_q.st == dbg_pkg::S_RXD && rx_valid && dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_CSWR; // see R8
  assign cs.wdata  = rx_data;
  assign cs.clr    = port_disable;
  assign cs.key_ok = s_q.key_ok;
  assign cs.lock   = lock_status;
  assign cs.busy   = s_q.st != dbg_pkg::S_IDLE;

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic       launch;
    logic [7:0] lop;
    logic       end_iter;
    logic       load_tx;
    logic [7:0] txb;
    logic       last;
    logic [3:0] gt_bits;
    launch   = 1'b0;
    lop      = s_q.op;
    end_iter = 1'b0;
    load_tx  = 1'b0;
    txb      = 8'h00;
    last     = (s_q.idx + 5'h01) >= s_q.cnt;
    gt_bits  = {1'b0, cs.gt_len} + 4'h1;
    s_d       = s_q;
    s_d.erase = 1'b0;

    unique case (s_q.st)
      dbg_pkg::S_IDLE: begin
        if (rx_sync) begin
          s_d.st = dbg_pkg::S_OPC;
        end
      end
      dbg_pkg::S_OPC: begin
        if (rx_valid) begin
          s_d.turn = 1'b1;
          launch   = 1'b1;
          lop      = rx_data;
        end
      end
      dbg_pkg::S_ADDR: begin
        if (rx_valid) begin
          s_d.turn = 1'b1;
          s_d.addr = put_byte(s_q.addr, s_q.idx, rx_data);
          s_d.idx  = s_q.idx + 5'h01;
          if (last) begin
            s_d.idx = 5'h00;
            s_d.cnt = dbg_pkg::op_bytes(s_q.op);
            if (dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_DWRITE) begin
              s_d.ack = 1'b1; // see R24
              s_d.mid = 1'b1;
              load_tx = 1'b1;
              txb     = dbg_pkg::ACK_BYTE;
              s_d.st  = dbg_pkg::S_TX;
            end else begin
              s_d.st = dbg_pkg::S_BUS;
            end
          end
        end
      end
      dbg_pkg::S_RXD: begin
        if (rx_valid) begin
          s_d.turn = 1'b1;
          s_d.idx  = s_q.idx + 5'h01;
          unique case (dbg_pkg::op_class(s_q.op))
            dbg_pkg::OP_CSWR: end_iter = 1'b1;
            dbg_pkg::OP_RPT: begin
              if (s_q.idx == 5'h00) begin
                s_d.rpt = rx_data; // see R9
              end
              end_iter = last;
            end
            dbg_pkg::OP_KEY: begin
              s_d.key = {rx_data, s_q.key[63:8]};
              if (last) begin
                // A key never answers; a match arms the erase
                if ({rx_data, s_q.key[63:8]} == ERASE_KEY) begin
                  s_d.key_ok = 1'b1; // see R22
                  s_d.erase  = 1'b1;
                end
                end_iter = 1'b1; // see R17
              end
            end
            default: begin
              if (dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_IWRITE && dbg_pkg::op_mode(s_q.op) == dbg_pkg::PTR_REG) begin
                s_d.ptr = put_byte(s_q.ptr, s_q.idx, rx_data);
                if (last) begin
                  s_d.pw  = s_q.op[1:0];
                  s_d.ack = 1'b1; // see R4
                  load_tx = 1'b1;
                  txb     = dbg_pkg::ACK_BYTE;
                  s_d.st  = dbg_pkg::S_TX;
                end
              end else begin
                s_d.data = put_byte(s_q.data, s_q.idx, rx_data);
                if (last) begin
                  s_d.idx = 5'h00;
                  s_d.st  = dbg_pkg::S_BUS;
                end
              end
            end
          endcase
        end
      end
      dbg_pkg::S_BUS: begin
        if (bus_ack) begin
          s_d.bus_req = 1'b0;
          if (s_q.bus_we) begin
            s_d.idx = s_q.idx + 5'h01;
            if (last) begin
              if (dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_IWRITE && dbg_pkg::op_mode(s_q.op) == dbg_pkg::PTR_INC) begin
                s_d.ptr = (s_q.ptr + {27'h0, s_q.cnt}) & width_mask(s_q.pw); // see R5
              end
              s_d.ack = 1'b1; // see R6
              load_tx = 1'b1;
              txb     = dbg_pkg::ACK_BYTE;
              s_d.st  = dbg_pkg::S_TX;
            end
          end else begin
            load_tx = 1'b1;
            txb     = bus_rdata;
            s_d.st  = dbg_pkg::S_TX;
          end
        end
      end
      dbg_pkg::S_TX: begin
        if (tx_ready) begin
          s_d.tx_valid = 1'b0;
          s_d.turn     = 1'b0; // see R14 R19
          if (s_q.ack) begin
            s_d.ack = 1'b0;
            if (s_q.mid) begin
              s_d.mid = 1'b0;
              s_d.idx = 5'h00;
              s_d.st  = dbg_pkg::S_RXD;
            end else begin
              end_iter = 1'b1;
            end
          end else if (!last) begin
            s_d.idx = s_q.idx + 5'h01;
            if (dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_KEY) begin
              load_tx = 1'b1;
              txb     = INFO_BLOCK[{s_d.idx[3:0], 3'h0} +: 8]; // see R20
            end else if (dbg_pkg::op_mode(s_q.op) == dbg_pkg::PTR_REG && !is_direct(s_q.op)) begin
              load_tx = 1'b1;
              txb     = byte_of(s_q.ptr, s_d.idx);
            end else begin
              s_d.st = dbg_pkg::S_BUS;
            end
          end else begin
            if (dbg_pkg::op_class(s_q.op) == dbg_pkg::OP_ILOAD && dbg_pkg::op_mode(s_q.op) == dbg_pkg::PTR_INC) begin
              s_d.ptr = (s_q.ptr + {27'h0, s_q.cnt}) & width_mask(s_q.pw); // see R1
            end
            end_iter = 1'b1;
          end
        end
      end
      default: s_d.st = dbg_pkg::S_IDLE;
    endcase

    // Later passes of a repeat restart from the stored opcode, skipping sync and opcode
    if (end_iter) begin
      if (s_q.rpt != 8'h00 && dbg_pkg::op_class(s_q.op) != dbg_pkg::OP_RPT) begin // see R10
        s_d.rpt = s_q.rpt - 8'h01; // see R25
        launch  = 1'b1; // see R11
        lop     = s_q.op;
      end else begin
        s_d.st = dbg_pkg::S_IDLE;
      end
    end

    if (launch) begin
      s_d.op  = lop;
      s_d.idx = 5'h00;
      s_d.cnt = dbg_pkg::op_bytes(lop);
      unique case (dbg_pkg::op_class(lop))
        dbg_pkg::OP_DREAD, dbg_pkg::OP_DWRITE: begin
          s_d.addr = 32'h0;
          s_d.st   = dbg_pkg::S_ADDR;
        end
        dbg_pkg::OP_ILOAD: begin
          if (dbg_pkg::op_mode(lop) == dbg_pkg::PTR_REG) begin
            load_tx = 1'b1; // see R2
            txb     = byte_of(s_d.ptr, 5'h00);
            s_d.st  = dbg_pkg::S_TX;
          end else begin
            s_d.st = dbg_pkg::S_BUS; // see R1
          end
        end
        dbg_pkg::OP_IWRITE: begin
          if (dbg_pkg::op_mode(lop) == dbg_pkg::PTR_REG) begin
            s_d.ptr = 32'h0;
          end
          s_d.st = dbg_pkg::S_RXD; // see R13
        end
        dbg_pkg::OP_CSRD: begin
          s_d.cnt = 5'h01; // see R7
          load_tx = 1'b1;
          txb     = cs.rdata;
          s_d.st  = dbg_pkg::S_TX;
        end
        dbg_pkg::OP_CSWR: begin
          s_d.cnt = 5'h01;
          s_d.st  = dbg_pkg::S_RXD;
        end
        dbg_pkg::OP_RPT: s_d.st = dbg_pkg::S_RXD;
        dbg_pkg::OP_KEY: begin
          if (lop[dbg_pkg::INFO_POS] && lop[1:0] == dbg_pkg::KLEN_8) begin
            s_d.cnt = dbg_pkg::INFO_SHORT; // see R20
          end else if (lop[dbg_pkg::INFO_POS] && lop[1:0] == dbg_pkg::KLEN_16) begin
            s_d.cnt = dbg_pkg::INFO_LONG;
          end else if (!lop[dbg_pkg::INFO_POS] && lop[1:0] == dbg_pkg::KLEN_8) begin
            s_d.cnt = dbg_pkg::KEY_BYTES; // see R16
          end else begin
            s_d.cnt = 5'h00;
          end
          if (s_d.cnt == 5'h00) begin
            s_d.st  = dbg_pkg::S_IDLE;
            s_d.rpt = 8'h00;
          end else if (lop[dbg_pkg::INFO_POS]) begin
            load_tx = 1'b1; // see R17
            txb     = INFO_BLOCK[7:0]; // see R21
            s_d.st  = dbg_pkg::S_TX;
          end else begin
            s_d.st = dbg_pkg::S_RXD;
          end
        end
      endcase
    end

    // Guard bits only right after receiving; otherwise just the optional byte gap
    if (load_tx) begin
      s_d.tx_valid = 1'b1;
      s_d.tx_data  = txb;
      s_d.tx_idle  = s_d.turn ? gt_bits : (cs.gap_en ? dbg_pkg::GAP_BITS : 4'h0); // see R18
    end

    if (s_d.st == dbg_pkg::S_BUS && (s_q.st != dbg_pkg::S_BUS || bus_ack)) begin
      s_d.bus_req   = 1'b1;
      s_d.bus_we    = dbg_pkg::op_class(s_d.op) == dbg_pkg::OP_DWRITE || dbg_pkg::op_class(s_d.op) == dbg_pkg::OP_IWRITE;
      s_d.bus_wdata = byte_of(s_d.data, s_d.idx);
      if (is_direct(s_d.op)) begin
        s_d.bus_addr = s_d.addr + {27'h0, s_d.idx};
      end else begin
        s_d.bus_addr = (s_d.ptr + {27'h0, s_d.idx}) & width_mask(s_d.pw); // see R26
      end
    end

    // A break stops a running sequence here; port disable stops it through the register reset
    if (rx_break) begin
      s_d.st       = dbg_pkg::S_IDLE; // see R12
      s_d.rpt      = 8'h00;
      s_d.tx_valid = 1'b0;
      s_d.bus_req  = 1'b0;
      s_d.ack      = 1'b0;
      s_d.mid      = 1'b0;
      s_d.erase    = 1'b0;
    end
  end

  // Disable clears keys, pointer and repeat state like a port reset
  always_ff @(posedge mclk) begin
    if (!rst_n || port_disable) begin
      s_q <= CORE_RESET; // see R22
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_valid    = s_q.tx_valid;
  assign tx_data     = s_q.tx_data;
  assign tx_idle     = s_q.tx_idle;
  assign bus_req     = s_q.bus_req;
  assign bus_we      = s_q.bus_we;
  assign bus_addr    = s_q.bus_addr;
  assign bus_wdata   = s_q.bus_wdata;
  assign erase_start = s_q.erase;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  cs_write_silent_a: assert property (cs.wr && !rx_break |=> !tx_valid) // see R8
    else $error("control write produced a response");
  guard_first_a: assert property ($rose(tx_valid) && s_q.turn |-> tx_idle == {1'b0, cs.gt_len} + 4'h1) // see R23
    else $error("first byte after receive lacks guard bits");
  same_dir_gap_a: assert property ($rose(tx_valid) && !s_q.turn |-> tx_idle == (cs.gap_en ? 4'h2 : 4'h0)) // see R18
    else $error("same-direction byte has wrong idle bits");
  break_stops_a: assert property (rx_break && !port_disable |=> s_q.st == dbg_pkg::S_IDLE && s_q.rpt == 8'h00) // see R12
    else $error("break did not stop the sequence");
  disable_clears_a: assert property (port_disable |=> s_q.ptr == 32'h0 && !s_q.key_ok && s_q.rpt == 8'h00) // see R26
    else $error("disable left pointer, key or repeat state");
  cs_read_one_a: assert property (s_q.st == dbg_pkg::S_OPC && rx_valid && !rx_break && !port_disable
      && rx_data[7:5] == dbg_pkg::OP_CSRD |=> tx_valid && s_q.cnt == 5'h01 && tx_data == $past(cs.rdata)) // see R7
    else $error("control read did not return one byte");
  erase_pulse_a: assert property (erase_start |=> !erase_start && s_q.key_ok) // see R22
    else $error("erase start not a single pulse with key held");
  repeat_count_a: assert property (s_q.st == dbg_pkg::S_TX && tx_ready && s_q.ack && !s_q.mid && s_q.rpt != 8'h00
      && !rx_break && !port_disable |=> s_q.rpt == $past(s_q.rpt) - 8'h01 && s_q.st != dbg_pkg::S_IDLE) // see R9
    else $error("repeat counter did not step on an iteration");

endmodule : onewire_debug_instruction_layer

/* verification/host_link.sv */
// Programmer model on the far side of the link
`timescale 1ns/1ps
module host_link (
  input  wire logic       mclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic [3:0] tx_idle,
  output logic            rx_sync,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_ready
);
  initial begin
    rx_sync = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'hff;
    tx_ready = 1'b0;
  end
  // ----
  // Frames
  // ----
  task automatic sync();
    @(posedge mclk);
    rx_sync <= 1'b1;
    @(posedge mclk);
    rx_sync <= 1'b0;
  endtask : sync
  // Idle data lines show the inverted byte, never a stale copy
  task automatic put(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : put
  // Ready only while waiting, so a stray answer is never swallowed
  task automatic get(input int stall, output logic [7:0] d, output logic [3:0] i);
    int n;
    n = 0;
    repeat (stall + 1) @(posedge mclk);
    tx_ready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (tx_valid !== 1'b1 && n < 400);
    d = (tx_valid === 1'b1) ? tx_data : 8'hxx;
    i = tx_idle;
    tx_ready <= 1'b0;
  endtask : get
endmodule : host_link

/* verification/tb_onewire_debug_instruction_layer.sv */
// Self-checking bench of the debug instruction layer
`timescale 1ns/1ps
module tb_onewire_debug_instruction_layer;
  localparam logic [127:0] INFO = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam logic [63:0]  KEY  = dbg_pkg::CHIP_ERASE_KEY;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dis = 1'b0;
  logic        brk = 1'b0;
  logic        bus_ack = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rx_sync, rx_valid, tx_ready, tx_valid, bus_req, bus_we, erase_start;
  logic [3:0]  reg_addr = 4'h0;
  logic [3:0]  tx_idle, i;
  logic [7:0]  bus_rdata = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  rx_data, tx_data, bus_wdata, reg_rdata, d, wd;
  logic [31:0] bus_addr, wa;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_er = 0;
  onewire_debug_instruction_layer #(.INFO_BLOCK(INFO), .ERASE_KEY(KEY)) DUT (
    .mclk(mclk), .rst_n(rst_n), .port_disable(dis), .rx_sync(rx_sync), .rx_break(brk),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_idle(tx_idle), .tx_ready(tx_ready), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .lock_status(1'b0), .erase_start(erase_start), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  host_link host (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_idle(tx_idle),
    .rx_sync(rx_sync), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
  always #25 mclk = ~mclk;
  // ----
  // Memory stand-in: answers a cycle after each request, data follow the address
  // ----
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    bus_ack <= bus_req && !bus_ack;
    bus_rdata <= bus_addr[7:0] ^ 8'h5a;
    if (bus_req && bus_ack && bus_we) begin
      wa <= bus_addr;
      wd <= bus_wdata;
    end
    if (erase_start === 1'b1)
      n_er <= n_er + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rx(input int s, input logic [7:0] e, input logic [3:0] ei);
    host.get(s, d, i);
    chk("tx_data", e, d);
    chk("tx_idle", {4'h0, ei}, {4'h0, i});
  endtask : rx
  task automatic fr(input logic [7:0] q[$]);
    host.sync();
    foreach (q[k]) host.put(q[k]);
  endtask : fr
  task automatic rg(input logic [3:0] a, input logic [7:0] w, input logic we, output logic [7:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= we;
    reg_rd <= !we;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge mclk);
    q = reg_rdata;
  endtask : rg
  task automatic t_store();
    fr('{8'h68, 8'h10});
    rx(0, 8'h40, 4'h2);
    fr('{8'h64, 8'ha5});
    rx(0, 8'h40, 4'h2);
    chk("wr_addr", 8'h10, wa[7:0]);
    chk("wr_data", 8'ha5, wd);
    fr('{8'h20});
    rx(2, 8'h11 ^ 8'h5a, 4'h2);
  endtask : t_store
  task automatic t_cs();
    rg(4'h2, 8'h05, 1'b1, d);
    fr('{8'h82});
    rx(0, 8'h05, 4'h6);
    fr('{8'hc2, 8'h83});
    repeat (6) @(posedge mclk);
    chk("tx_valid", 8'h00, {7'h0, tx_valid});
    rg(4'h2, 8'h00, 1'b0, d);
    chk("ctrl", 8'h83, d);
    rg(4'hf, 8'h00, 1'b0, d);
    chk("unmapped", 8'h00, d);
  endtask : t_cs
  task automatic t_rpt();
    fr('{8'ha0, 8'h02});
    fr('{8'h24});
    rx(0, 8'h11 ^ 8'h5a, 4'h4);
    rx(5, 8'h12 ^ 8'h5a, 4'h2);
    rx(0, 8'h13 ^ 8'h5a, 4'h2);
    fr('{8'h20});
    rx(0, 8'h14 ^ 8'h5a, 4'h4);
    repeat (8) @(posedge mclk);
    chk("tx_valid", 8'h00, {7'h0, tx_valid});
    fr('{8'ha0, 8'h03});
    brk <= 1'b1;
    @(posedge mclk);
    brk <= 1'b0;
  endtask : t_rpt
  task automatic t_info();
    for (int n = 8; n <= 16; n += 8) begin
      fr('{(n == 16) ? 8'he5 : 8'he4});
      for (int k = 0; k < n; k++)
        rx(0, INFO[8*k +: 8], (k == 0) ? 4'h4 : 4'h2);
    end
  endtask : t_info
  task automatic t_key();
    fr('{8'he0});
    for (int k = 0; k < 8; k++)
      host.put(KEY[8*k +: 8]);
    repeat (6) @(posedge mclk);
    chk("erase_pulses", 8'h01, n_er[7:0]);
    chk("tx_valid", 8'h00, {7'h0, tx_valid});
    rg(4'h0, 8'h00, 1'b0, d);
    chk("key_flag", 8'h01, {7'h0, d[2]});
    @(posedge mclk);
    dis <= 1'b1;
    @(posedge mclk);
    dis <= 1'b0;
    rg(4'h0, 8'h00, 1'b0, d);
    chk("key_flag", 8'h00, {7'h0, d[2]});
    fr('{8'h20});
    rx(0, 8'h5a, 4'h2);
  endtask : t_key
  task automatic t_rptw();
    fr('{8'ha0, 8'h01});
    fr('{8'h64, 8'h3c});
    rx(0, 8'h40, 4'h2);
    host.put(8'hc3);
    rx(0, 8'h40, 4'h2);
    chk("wr_addr", 8'h01, wa[7:0]);
    chk("wr_data", 8'hc3, wd);
  endtask : t_rptw
  task automatic t_dir();
    fr('{8'h40, 8'h30});
    rx(0, 8'h40, 4'h2);
    host.put(8'h77);
    rx(0, 8'h40, 4'h2);
    chk("wr_addr", 8'h30, wa[7:0]);
    fr('{8'ha0, 8'h01});
    fr('{8'h00, 8'h31});
    rx(0, 8'h6b, 4'h2);
    host.put(8'h32);
    rx(0, 8'h68, 4'h2);
  endtask : t_dir
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_store();
    t_cs();
    t_rpt();
    t_info();
    t_key();
    t_rptw();
    t_dir();
    end_sim();
  end
endmodule : tb_onewire_debug_instruction_layer
